// ---- rtl/cc3_pkg.sv ----
// Constants, field layouts and carrier types of the channel 3 capture/compare block.
package cc3_pkg;

  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int BE_W = 4;
  localparam int EVT_W = 2;

  typedef logic [DATA_W-1:0] word_type;
  typedef logic [CNT_W-1:0] count_type;

  // Byte addresses of the registers.
  localparam logic [DATA_W-1:0] CHANNEL3_COMPARE_BUFFER_ADDR = 32'hFFFFF54C;
  localparam logic [DATA_W-1:0] CTRL_ADDR = 32'hFFFFF550;
  localparam logic [DATA_W-1:0] STATUS_ADDR = 32'hFFFFF554;
  localparam logic [DATA_W-1:0] MASK_ADDR = 32'hFFFFF558;
  localparam logic [DATA_W-1:0] COUNT_ADDR = 32'hFFFFF55C;

  // Byte lanes that must all be enabled for a write.
  localparam logic [1:0] HALF_LANES = 2'h3;
  localparam logic [0:0] LOW_LANE = 1'h1;

  // Reset values.
  localparam count_type CHANNEL3_COMPARE_BUFFER_RESET = 16'h0000;
  localparam count_type BUFFER_RESET = 16'h0000;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

  // Operation modes of the timer.
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_EXT_EVENT = 3'h1;
  localparam logic [2:0] MODE_EXT_TRIGGER = 3'h2;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h3;
  localparam logic [2:0] MODE_PWM = 3'h4;
  localparam logic [2:0] MODE_FREE_RUN = 3'h5;
  localparam logic [2:0] MODE_PULSE_WIDTH = 3'h6;

  // Valid edge selection of the capture input.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Control register layout, low byte of the word.
  typedef struct packed {
    logic [1:0] edge_sel;
    logic output_en;
    logic channel3_capture_select;
    logic count_enable_bit;
    logic [2:0] mode;
  } ctrl_type;

  localparam int CTRL_W = 8;
  localparam ctrl_type CTRL_RESET = 8'h00;

  // Sticky event bits, shared by the status and mask registers.
  typedef struct packed {
    logic capture;
    logic match;
  } event_type;

  // Bus handshake states.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_type;

endpackage : cc3_pkg

// ---- rtl/edge_detect.sv ----
// Two-stage pin synchroniser with selectable valid-edge detection.
`timescale 1ns/1ps
module edge_detect
  import cc3_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pin and edge choice
  input wire logic pin_in,
  input wire logic [1:0] edge_sel,
  // Detected edge, one cycle
  output logic edge_valid_r
);

  logic sync1_r;
  logic sync2_r;
  logic last_r;
  wire rise = sync2_r & ~last_r;
  wire fall = ~sync2_r & last_r;
  wire want_rise = (edge_sel == EDGE_RISE) | (edge_sel == EDGE_BOTH);
  wire want_fall = (edge_sel == EDGE_FALL) | (edge_sel == EDGE_BOTH);
  wire edge_nxt = (rise & want_rise) | (fall & want_fall);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r <= 1'b0;
      edge_valid_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      last_r <= sync2_r;
      edge_valid_r <= edge_nxt;
    end
  end

endmodule : edge_detect

// ---- rtl/timer_capture_compare_ch3.sv ----
// Channel 3 capture/compare unit of a 16-bit timer with an Avalon-MM register slave.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1 - free-running mode: select bit picks capture or compare
// R2 - pulse width mode: capture only
// R3 - all other modes: compare only
// R4 - read/write while running, whole 16-bit word
// R5 - reset clears the register to zero
// R6 - software avoids access on slow clocks
// R7 - compare writes accepted while counting enabled
// R8 - writes go to buffer; compare uses buffer
// R9 - counter equals buffer raises match interrupt
// R10 - match inverts enabled timer output
// R11 - free-running capture stores counter on edge
// R12 - pulse width capture stores, clears counter
// R13 - read during capture returns consistent value
// R14 - batch write in trigger/PWM modes, else anytime
// R15 - anytime copies at once, batch at boundary
module timer_capture_compare_ch3
  import cc3_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [DATA_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [BE_W-1:0] byteenable,
  input wire logic [DATA_W-1:0] writedata,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  // Timer counter
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic period_boundary,
  output logic counter_clear,
  // Pins
  input wire logic channel3_capture_input,
  output logic channel3_timer_output,
  // Events
  output logic channel3_match_irq,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  bus_state_type bus_state_r;
  bus_state_type bus_state_nxt;
  logic waitrequest_r;
  logic waitrequest_nxt;
  word_type readdata_r;
  word_type readdata_nxt;

  count_type channel3_compare_buffer_r;
  count_type channel3_compare_buffer_nxt;
  count_type buffer_r;
  count_type buffer_nxt;
  logic pending_r;
  logic pending_nxt;

  ctrl_type ctrl_r;
  ctrl_type ctrl_nxt;
  event_type status_r;
  event_type status_nxt;
  event_type mask_r;
  event_type mask_nxt;

  logic match_seen_r;
  logic timer_out_r;
  logic timer_out_nxt;
  logic match_irq_r;
  logic counter_clear_r;
  logic irq_r;
  logic match_seen_nxt;
  logic match_irq_nxt;
  logic counter_clear_nxt;
  logic irq_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  // The full byte address is decoded; each register is one aligned word.
  wire req = read | write;
  wire hit_channel3_compare_buffer = address == CHANNEL3_COMPARE_BUFFER_ADDR;
  wire hit_ctrl = address == CTRL_ADDR;
  wire hit_status = address == STATUS_ADDR;
  wire hit_mask = address == MASK_ADDR;
  wire hit_count = address == COUNT_ADDR;

  // The access completes in the ack state while the master still holds it.
  wire bus_fire = (bus_state_r == BUS_ACK) & req;
  wire wr_fire = bus_fire & write;

  // Writes with missing lanes or to no register are still answered, so the
  // master never stalls; they simply change nothing.
  wire half_lanes = byteenable[1:0] == HALF_LANES;
  wire low_lane = byteenable[0] == LOW_LANE;

  wire channel3_compare_buffer_wr = wr_fire & hit_channel3_compare_buffer & half_lanes; // see R4
  // Control, status and mask writes need only the low byte lane.
  wire ctrl_wr = wr_fire & hit_ctrl & low_lane;
  wire status_wr = wr_fire & hit_status & low_lane;
  wire mask_wr = wr_fire & hit_mask & low_lane;

  wire [CNT_W-1:0] wr_half = writedata[CNT_W-1:0];
  wire [CTRL_W-1:0] wr_byte = writedata[CTRL_W-1:0];
  wire [EVT_W-1:0] wr_evt = writedata[EVT_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Read data selection

  // Captured value is sampled whole at one edge, so a capture in flight never
  // splits the word the master sees.
  wire [DATA_W-1:0] rd_channel3_compare_buffer = word_type'(channel3_compare_buffer_r); // see R13
  wire [DATA_W-1:0] rd_ctrl = word_type'(ctrl_r);
  wire [DATA_W-1:0] rd_status = word_type'({pending_r, status_r});
  wire [DATA_W-1:0] rd_mask = word_type'(mask_r);
  wire [DATA_W-1:0] rd_count = word_type'(counter_value);

  // Addresses that hit no register read as zero.
  wire [DATA_W-1:0] rd_mux =
    hit_channel3_compare_buffer ? rd_channel3_compare_buffer :
    hit_ctrl ? rd_ctrl :
    hit_status ? rd_status :
    hit_mask ? rd_mask :
    hit_count ? rd_count :
    word_type'(CHANNEL3_COMPARE_BUFFER_RESET);

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // Every access costs exactly one wait state. The ack state always falls back
  // to idle, so a request that the master still holds at the answering edge is
  // never served twice, and a new one is taken from the following edge on.
  always_comb begin
    bus_state_nxt = bus_state_r;
    waitrequest_nxt = waitrequest_r;
    readdata_nxt = readdata_r;
    unique case (bus_state_r)
      BUS_IDLE: begin
        if (req) begin
          bus_state_nxt = BUS_ACK;
          waitrequest_nxt = 1'b0;
          readdata_nxt = rd_mux;
        end
      end
      BUS_ACK: begin
        bus_state_nxt = BUS_IDLE;
        waitrequest_nxt = 1'b1;
      end
      default: begin
        bus_state_nxt = BUS_IDLE;
        waitrequest_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_state_r <= BUS_IDLE;
      waitrequest_r <= 1'b1;
      readdata_r <= word_type'(CHANNEL3_COMPARE_BUFFER_RESET);
    end else begin
      bus_state_r <= bus_state_nxt;
      waitrequest_r <= waitrequest_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel role

  // The channel role follows the mode and the capture select bit.
  wire [2:0] mode = ctrl_r.mode;
  wire counting = ctrl_r.count_enable_bit;
  wire mode_free_run = mode == MODE_FREE_RUN;
  wire mode_pulse_width = mode == MODE_PULSE_WIDTH;

  // Codes with no mode of their own fall in the compare-only group.
  wire role_capture = mode_pulse_width | // see R2
    (mode_free_run & ctrl_r.channel3_capture_select); // see R1
  wire role_compare = ~role_capture; // see R3

  // Batch modes defer compare writes made while counting to the period boundary.
  wire batch_mode = (mode == MODE_EXT_TRIGGER) | (mode == MODE_PWM); // see R14

  //////////////////////////////////////////////////////////////////////////////
  // Capture input

  // The pin passes two synchroniser flops and an edge flop, so a capture lands
  // on the fourth edge after the pin moves.
  logic edge_valid;

  edge_detect capture_edge (
    .clk(clk),
    .rstn(rstn),
    .pin_in(channel3_capture_input),
    .edge_sel(ctrl_r.edge_sel),
    .edge_valid_r(edge_valid)
  );

  wire capture_evt = role_capture & counting & edge_valid; // see R11
  wire clear_evt = capture_evt & mode_pulse_width; // see R12

  //////////////////////////////////////////////////////////////////////////////
  // Capture/compare register

  // A capture outranks a software write landing in the same cycle.
  always_comb begin
    channel3_compare_buffer_nxt = channel3_compare_buffer_r;
    if (capture_evt) begin
      channel3_compare_buffer_nxt = counter_value; // see R11
    end else if (channel3_compare_buffer_wr) begin
      channel3_compare_buffer_nxt = wr_half; // see R4
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel3_compare_buffer_r <= CHANNEL3_COMPARE_BUFFER_RESET; // see R5
    end else begin
      channel3_compare_buffer_r <= channel3_compare_buffer_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare buffer

  // Writes are taken regardless of the count enable bit.
  wire cmp_wr = channel3_compare_buffer_wr & role_compare; // see R7
  // With the count stopped there is no period to protect.
  wire batch_wr = cmp_wr & batch_mode & counting; // see R14
  wire load_now = cmp_wr & ~batch_wr; // see R15
  wire boundary_load = period_boundary & (pending_r | batch_wr); // see R15
  // A batch write that lands on the boundary edge itself goes straight in, so
  // the next period never starts from a stale value.
  wire [CNT_W-1:0] boundary_value = channel3_compare_buffer_wr ? wr_half : channel3_compare_buffer_r;

  // The pending flag marks a batch value that waits for the boundary.
  always_comb begin
    buffer_nxt = buffer_r;
    pending_nxt = pending_r;
    if (load_now) begin
      buffer_nxt = wr_half; // see R8
    end else if (boundary_load) begin
      buffer_nxt = boundary_value; // see R8
    end
    if (boundary_load) begin
      pending_nxt = 1'b0;
    end else if (batch_wr) begin
      pending_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buffer_r <= BUFFER_RESET;
      pending_r <= 1'b0;
    end else begin
      buffer_r <= buffer_nxt;
      pending_r <= pending_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare match

  // Only the first cycle of equality counts, so a slow counter that rests on
  // the match value raises one event.
  wire match_now = counting & role_compare & (counter_value == buffer_r);
  wire match_evt = match_now & ~match_seen_r; // see R9

  // The seen flag holds the equality of the cycle before.
  assign match_seen_nxt = match_now;
  assign match_irq_nxt = match_evt; // see R9
  assign counter_clear_nxt = clear_evt; // see R12

  // The output toggles only while its driver is enabled.
  always_comb begin
    timer_out_nxt = timer_out_r;
    if (match_evt & ctrl_r.output_en) begin
      timer_out_nxt = ~timer_out_r; // see R10
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_seen_r <= 1'b0;
      timer_out_r <= 1'b0;
      match_irq_r <= 1'b0;
      counter_clear_r <= 1'b0;
    end else begin
      match_seen_r <= match_seen_nxt;
      timer_out_r <= timer_out_nxt;
      match_irq_r <= match_irq_nxt;
      counter_clear_r <= counter_clear_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control, status and mask

  // Set and clear vectors share the status layout.
  event_type evt_set;
  event_type evt_clr;

  assign evt_set = {capture_evt, match_evt};
  assign evt_clr = status_wr ? event_type'(wr_evt) : event_type'(EVT_RESET);

  // A new event wins over a clear in the same cycle.
  assign status_nxt = (status_r & ~evt_clr) | evt_set;
  assign mask_nxt = mask_wr ? event_type'(wr_evt) : mask_r;
  assign ctrl_nxt = ctrl_wr ? ctrl_type'(wr_byte) : ctrl_r;

  // The interrupt level follows the status one cycle late, so it leaves a flop.
  assign irq_nxt = |(status_r & mask_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
      status_r <= event_type'(EVT_RESET);
      mask_r <= event_type'(EVT_RESET);
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every output is a flop, with no logic after it.
  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign counter_clear = counter_clear_r;
  assign channel3_timer_output = timer_out_r;
  assign channel3_match_irq = match_irq_r;
  assign irq = irq_r;

endmodule : timer_capture_compare_ch3

// ---- tb/cc3_sva.sv ----
// Port-level checker of the channel 3 capture/compare block.
`timescale 1ns/1ps
module cc3_sva
  import cc3_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus side
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest,
  // Timer side
  input wire logic counter_clear,
  input wire logic channel3_capture_input,
  input wire logic channel3_timer_output,
  input wire logic channel3_match_irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_wait_one: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  a_req_answer: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
    else $error("no answer");
  a_idle_wait: assert property (waitrequest && !read && !write |=> waitrequest)
    else $error("answer without request");
  a_rd_upper: assert property (!waitrequest && read |-> readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_irq_pulse: assert property (channel3_match_irq |=> !channel3_match_irq)
    else $error("match pulse too long");
  a_out_toggle: assert property ($changed(channel3_timer_output) |-> channel3_match_irq)
    else $error("output moved without match");
  a_clear_pulse: assert property (counter_clear |=> !counter_clear)
    else $error("clear pulse too long");
  a_clear_cause: assert property (counter_clear |->
    $past(channel3_capture_input, 4) != $past(channel3_capture_input, 5))
    else $error("clear without pin edge");
endmodule : cc3_sva

bind timer_capture_compare_ch3 cc3_sva i_sva (.clk(clk), .rstn(rstn), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest), .counter_clear(counter_clear),
  .channel3_capture_input(channel3_capture_input),
  .channel3_timer_output(channel3_timer_output), .channel3_match_irq(channel3_match_irq));

// ---- tb/count_model.sv ----
// Behavioural 16-bit timer counter standing on the channel's counter side.
`timescale 1ns/1ps
module count_model
  import cc3_pkg::*;
#(
  parameter int PERIOD = 64
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Counter side
  input wire logic counter_clear,
  output count_type counter_value,
  output logic period_boundary
);
  assign period_boundary = (counter_value == count_type'(PERIOD - 1));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      counter_value <= 16'h0000;
    end else if (counter_clear || period_boundary) begin
      counter_value <= 16'h0000;
    end else begin
      counter_value <= counter_value + 16'h0001;
    end
  end
endmodule : count_model

// ---- tb/timer_capture_compare_ch3_tb.sv ----
// Self-checking bench of the channel 3 capture/compare block.
`timescale 1ns/1ps
module timer_capture_compare_ch3_tb
  import cc3_pkg::*;
;
  logic clk, rstn, read, write, pin, waitrequest, period_boundary, counter_clear;
  logic out, match, irq, o;
  logic [BE_W-1:0] byteenable;
  word_type address, writedata, readdata, q;
  count_type counter_value, v;
  int err_total, checked, cyc;

  timer_capture_compare_ch3 i_dut (
    .clk(clk),
    .rstn(rstn),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .counter_value(counter_value),
    .period_boundary(period_boundary),
    .counter_clear(counter_clear),
    .channel3_capture_input(pin),
    .channel3_timer_output(out),
    .channel3_match_irq(match),
    .irq(irq)
  );

  count_model i_cnt (
    .clk(clk),
    .rstn(rstn),
    .counter_clear(counter_clear),
    .counter_value(counter_value),
    .period_boundary(period_boundary)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input word_type seen, input word_type exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Software reaches the registers only while the main clock runs.
  task automatic bus(input word_type a, input logic w, input word_type d, input logic [3:0] be);
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge clk);
    end while (waitrequest);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input word_type a, input word_type d);
    bus(a, 1'b1, d, 4'hF);
  endtask : wr

  task automatic rd(input word_type a, input word_type e);
    bus(a, 1'b0, 32'h0, 4'hF);
    chk(q, e);
  endtask : rd

  // Writes a known value, raises the pin and sees whether the counter was captured.
  task automatic cap(input logic [7:0] c, input logic hit);
    wr(CTRL_ADDR, {24'h0, c});
    wr(CHANNEL3_COMPARE_BUFFER_ADDR, 32'h0ABC);
    @(posedge clk);
    pin <= 1'b1;
    fork
      begin
        repeat (2) @(posedge clk);
        rd(CHANNEL3_COMPARE_BUFFER_ADDR, 32'h0ABC);
      end
      begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        v = counter_value;
        @(negedge clk);
        chk({31'h0, counter_clear}, {31'h0, hit && c[2:0] == MODE_PULSE_WIDTH});
      end
    join
    rd(CHANNEL3_COMPARE_BUFFER_ADDR, hit ? {16'h0, v} : 32'h0ABC);
    pin <= 1'b0;
  endtask : cap

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    pin = 1'b0;
    address = 32'h0;
    writedata = 32'h0;
    byteenable = 4'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd(CHANNEL3_COMPARE_BUFFER_ADDR, 32'h0);
    bus(CHANNEL3_COMPARE_BUFFER_ADDR, 1'b1, 32'h1234, 4'h1);
    rd(CHANNEL3_COMPARE_BUFFER_ADDR, 32'h0);
    wr(32'hFFFFF560, 32'h5A5A);
    rd(32'hFFFFF560, 32'h0);
    wr(MASK_ADDR, 32'h1);
    o = 1'b0;
    // Batch modes still match on the old buffer before the next period boundary.
    for (int m = 0; m < 6; m++) begin
      @(negedge clk iff period_boundary);
      wr(CTRL_ADDR, word_type'(32'h28 + m));
      wr(CHANNEL3_COMPARE_BUFFER_ADDR, word_type'(32'h20 + m));
      @(negedge clk iff match);
      o = !o;
      chk({16'h0, counter_value}, word_type'((m == 2 || m == 4) ? 32'h20 + m : 32'h21 + m));
      chk({31'h0, out}, {31'h0, o});
    end
    wr(CTRL_ADDR, 32'h0);
    rd(STATUS_ADDR, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(MASK_ADDR, 32'h0);
    rd(STATUS_ADDR, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(STATUS_ADDR, 32'h1);
    rd(STATUS_ADDR, 32'h0);
    cap(8'h5D, 1'b1);
    cap(8'h4D, 1'b0);
    cap(8'h4E, 1'b1);
    cap(8'h48, 1'b0);
    cap(8'h1D, 1'b0);
    cap(8'h9D, 1'b0);
    cap(8'hDD, 1'b1);
    test_done();
  end
endmodule : timer_capture_compare_ch3_tb
